// ---- rtl/lfr_pkg.sv ----
package lfr_pkg;
	// ****************************************************************
	// geometry and register map
	// ****************************************************************
	localparam int             NCH         = 4;
	localparam int             AW          = 3;
	localparam int             DW          = 8;
	localparam logic [AW-1:0]  REG_GLOBAL  = 3'h0;
	localparam logic [AW-1:0]  REG_CH_BASE = 3'h1;
	localparam logic [AW-1:0]  REG_STATUS  = 3'h5;
	localparam logic [AW-1:0]  REG_RANGE   = 3'h6;
	// ****************************************************************
	// channel control fields
	// ****************************************************************
	localparam int             CF_EN       = 0;
	localparam int             CF_BAND     = 1;
	localparam int             CF_RATE     = 3;
	localparam int             CF_OE1      = 4;
	localparam int             CF_OE2      = 5;
	localparam logic [DW-1:0]  CFG_RST     = 8'h00;
	localparam logic [1:0]     THRESH_RST  = 2'h0;
	localparam logic [1:0]     AMP_OFF     = 2'h0;
	localparam logic [1:0]     BAND_LOW    = 2'h0;
	localparam logic [1:0]     BAND_MID    = 2'h1;
	localparam logic [1:0]     BAND_HIGH   = 2'h2;
	// ****************************************************************
	// monitors and timing
	// ****************************************************************
	localparam int             IDLE_W      = 3;
	localparam logic [2:0]     NO_TRANS_CHARS = 3'h6;
	localparam int             TRAIN_W     = 8;
	localparam logic [7:0]     TRAIN_LOSS  = 8'h40;
	localparam int             CNT_W       = 16;
	localparam int             RANGE_PERIOD_DEF = 4096;
	localparam int             RANGE_TOL_PPM    = 1500;
	localparam int             PPM_SCALE        = 1000000;
	localparam int             CLK_PERIOD_NS    = 8;
	localparam int             ENABLE_SETTLE_NS = 2000000;
	localparam int             RECLK_SETTLE_NS  = 250000;
	localparam int             SETTLE_W    = 18;
	localparam int             RK_W        = 15;
	localparam int             ENABLE_SETTLE_DEF =
		(ENABLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int             RECLK_SETTLE_DEF  =
		(RECLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lfr_pkg

// ---- rtl/lfr_sync.sv ----
`timescale 1ns/1ps
module lfr_sync
	import lfr_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lfr_sync_st_t;

	lfr_sync_st_t st;
	lfr_sync_st_t next_st;

	always_comb
	begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign q_o = st.s2;
endmodule : lfr_sync

// ---- rtl/lfr_range_ctl.sv ----
`timescale 1ns/1ps
module lfr_range_ctl
	import lfr_pkg::*;
#(
	parameter int PERIOD = RANGE_PERIOD_DEF
)(
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	input  wire logic enable_i,
	input  wire logic char_tick_i,
	input  wire logic train_tick_i,
	input  wire logic half_rate_i,
	output logic      force_o,
	output logic      locked_o
);
	localparam int TOL_RAW = PERIOD * RANGE_TOL_PPM / PPM_SCALE;
	localparam int TOL     = (TOL_RAW < 1) ? 1 : TOL_RAW;

	typedef struct packed {
		logic [CNT_W-1:0] char_cnt;
		logic [CNT_W-1:0] train_cnt;
		logic             forcing;
		logic             locked;
	} lfr_range_st_t;

	lfr_range_st_t    st;
	lfr_range_st_t    next_st;
	logic             window_end;
	logic [CNT_W-1:0] expect_cnt;
	logic [CNT_W-1:0] diff;

	assign window_end = char_tick_i && (st.char_cnt == CNT_W'(PERIOD - 1));
	// half-rate training clock gives half the edges per window
	assign expect_cnt = half_rate_i ? CNT_W'(PERIOD / 2) : CNT_W'(PERIOD);
	assign diff = (st.train_cnt > expect_cnt) ? st.train_cnt - expect_cnt
		: expect_cnt - st.train_cnt;

	always_comb
	begin
		next_st = st;
		if (!enable_i)
		begin
			next_st = '0;
		end
		else
		begin
			if (train_tick_i && (st.train_cnt != '1))
				next_st.train_cnt = st.train_cnt + CNT_W'(1);
			if (char_tick_i)
				next_st.char_cnt = st.char_cnt + CNT_W'(1);
			if (window_end)
			begin
				next_st.char_cnt  = '0;
				next_st.train_cnt = '0;
				if (st.forcing)
				begin
					// release after one forced window, then prove lock
					next_st.forcing = 1'b0;
					next_st.locked  = 1'b0;
				end
				else if (diff > CNT_W'(TOL))
				begin
					next_st.forcing = 1'b1;
					next_st.locked  = 1'b0;
				end
				else
				begin
					next_st.locked = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign force_o  = st.forcing;
	assign locked_o = st.locked;

	AST_FORCE_HOLDS_WINDOW: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		st.forcing && enable_i && !window_end |=> st.forcing)
		else $error("forcing dropped inside a window");
	AST_FORCE_RELEASES: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		st.forcing && window_end && enable_i |=> !st.forcing && !st.locked)
		else $error("forcing not released at window end");
	AST_NO_LOCK_WHILE_FORCE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		st.forcing |-> !st.locked)
		else $error("locked while tracking training clock");
endmodule : lfr_range_ctl

// ---- rtl/lfr_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - valid only when all eight conditions hold
// - fault output updates on recovered character tick
// - threshold code 00 off, 01..11 rising levels
// - one threshold shared by all channels
// - amplitude taken from selected line receiver
// - no transition over six characters gives fault
// - out-of-range oscillator forced then released
// - range window is 4096 character periods
// - fault low while forced; lock within window
// - speed band select picks rate band
// - low band with half-rate training reserved
// - training clock full or half character rate
// - power enable 0 disables loop, constant fault
// - fault held for 2 ms after re-enable
// - loop follows training clock while out of range
// - select high primary, low secondary
// - retimed data driven to reclocker outputs
// - drivers enabled apart; both off powers down
// - reset disables all reclocker drivers
// - reclocker outputs quiet 250 us after re-enable
module lfr_top
	import lfr_pkg::*;
#(
	parameter int RANGE_PERIOD_CHARS = RANGE_PERIOD_DEF,
	parameter int ENABLE_SETTLE_CYC  = ENABLE_SETTLE_DEF,
	parameter int RECLK_SETTLE_CYC   = RECLK_SETTLE_DEF
)(
	input  wire logic              sys_clk_i,
	input  wire logic              nrst_i,
	input  wire logic [AW-1:0]     reg_addr_i,
	input  wire logic [DW-1:0]     reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DW-1:0]     reg_rdata_o,
	input  wire logic [NCH-1:0]    line_input_select_i,
	input  wire logic [NCH-1:0]    primary_serial_in_i,
	input  wire logic [NCH-1:0]    secondary_serial_in_i,
	input  wire logic [2*NCH-1:0]  primary_amp_level_i,
	input  wire logic [2*NCH-1:0]  secondary_amp_level_i,
	input  wire logic [NCH-1:0]    recovered_clock_i,
	input  wire logic [NCH-1:0]    training_clock_i,
	input  wire logic [NCH-1:0]    forced_fault_request_i,
	output logic      [NCH-1:0]    link_fault_out_n_o,
	output logic      [NCH-1:0]    loop_enable_o,
	output logic      [NCH-1:0]    force_training_o,
	output logic      [2*NCH-1:0]  speed_band_o,
	output logic      [NCH-1:0]    reclock_logic_en_o,
	output logic      [NCH-1:0]    reclock_out1_en_o,
	output logic      [NCH-1:0]    reclock_out2_en_o,
	output logic      [NCH-1:0]    reclock_out1_o,
	output logic      [NCH-1:0]    reclock_out2_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [1:0]                         thresh;
		logic [NCH-1:0][DW-1:0]             cfg;
		logic [DW-1:0]                      rdata;
		logic [NCH-1:0]                     char_d;
		logic [NCH-1:0]                     train_d;
		logic [NCH-1:0]                     data_d;
		logic [NCH-1:0][IDLE_W-1:0]         idle_chars;
		logic [NCH-1:0][TRAIN_W-1:0]        train_idle;
		logic [NCH-1:0]                     fault_n;
		logic [NCH-1:0][1:0]                band;
		logic [NCH-1:0][SETTLE_W-1:0]       en_settle;
		logic [NCH-1:0][RK_W-1:0]           rk_settle;
		logic [NCH-1:0]                     rk_on;
		logic [NCH-1:0]                     rk1;
		logic [NCH-1:0]                     rk2;
	} lfr_top_st_t;

	lfr_top_st_t st;
	lfr_top_st_t next_st;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic amp_ok(input logic [1:0] thr, input logic [1:0] lvl);
		amp_ok = (thr == AMP_OFF) || (lvl >= thr);
	endfunction : amp_ok

	function automatic logic [1:0] band_decode(input logic [1:0] code);
		// the undriven "open" code behaves as the middle band
		if (code == BAND_LOW)
			band_decode = BAND_LOW;
		else if (code == BAND_HIGH)
			band_decode = BAND_HIGH;
		else
			band_decode = BAND_MID;
	endfunction : band_decode

	function automatic logic ch_hit(input logic [AW-1:0] a, input int c);
		ch_hit = (a == REG_CH_BASE + AW'(c));
	endfunction : ch_hit

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	localparam int SW = 6 * NCH + 4 * NCH;
	logic [SW-1:0]      sync_q;
	logic [NCH-1:0]     sel_s;
	logic [NCH-1:0]     pri_s;
	logic [NCH-1:0]     sec_s;
	logic [NCH-1:0]     rclk_s;
	logic [NCH-1:0]     tclk_s;
	logic [NCH-1:0]     ffr_s;
	logic [2*NCH-1:0]   pamp_s;
	logic [2*NCH-1:0]   samp_s;

	lfr_sync #(.W(SW)) u_sync (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.d_i       ({line_input_select_i, primary_serial_in_i, secondary_serial_in_i,
			recovered_clock_i, training_clock_i, forced_fault_request_i,
			primary_amp_level_i, secondary_amp_level_i}),
		.q_o       (sync_q)
	);
	assign {sel_s, pri_s, sec_s, rclk_s, tclk_s, ffr_s, pamp_s, samp_s} = sync_q;

	// ****************************************************************
	// per-channel ticks and range controllers
	// ****************************************************************
	logic [NCH-1:0] char_tick;
	logic [NCH-1:0] train_tick;
	logic [NCH-1:0] sel_data;
	logic [NCH-1:0] forcing;
	logic [NCH-1:0] locked;

	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		assign char_tick[g]  = rclk_s[g] && !st.char_d[g];
		assign train_tick[g] = tclk_s[g] && !st.train_d[g];
		assign sel_data[g]   = sel_s[g] ? pri_s[g] : sec_s[g];

		lfr_range_ctl #(.PERIOD(RANGE_PERIOD_CHARS)) u_range (
			.sys_clk_i    (sys_clk_i),
			.nrst_i       (nrst_i),
			.enable_i     (st.cfg[g][CF_EN]),
			.char_tick_i  (char_tick[g]),
			.train_tick_i (train_tick[g]),
			.half_rate_i  (st.cfg[g][CF_RATE]),
			.force_o      (forcing[g]),
			.locked_o     (locked[g])
		);

		AST_DISABLED_FAULT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			!st.cfg[g][CF_EN] && !next_st.cfg[g][CF_EN]
			|=> !link_fault_out_n_o[g] && !loop_enable_o[g])
			else $error("disabled channel not faulted");
		AST_FORCE_FAULT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			forcing[g] && char_tick[g] |=> !link_fault_out_n_o[g])
			else $error("fault not low while forcing");
		AST_NO_TRANSITION: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			(st.idle_chars[g] > NO_TRANS_CHARS) && char_tick[g] |=> !link_fault_out_n_o[g])
			else $error("fault missed after six idle characters");
		AST_FORCED_REQ: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			ffr_s[g] && char_tick[g] |=> !link_fault_out_n_o[g])
			else $error("forced fault request ignored");
		AST_FAULT_ON_TICK: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			!char_tick[g] && st.cfg[g][CF_EN] && next_st.cfg[g][CF_EN]
			|=> $stable(link_fault_out_n_o[g]))
			else $error("fault changed without character tick");
		AST_RECLK_OFF: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			!(st.cfg[g][CF_OE1] || st.cfg[g][CF_OE2]) |=> !reclock_logic_en_o[g]
			##1 (!reclock_out1_o[g] && !reclock_out2_o[g]))
			else $error("reclocker active with both drivers off");
		AST_SETTLE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
			$rose(st.cfg[g][CF_EN]) |-> !link_fault_out_n_o[g] [*8])
			else $error("fault released during enable settle");
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic [1:0] lvl;
		logic       valid;
		lvl     = 2'h0;
		valid   = 1'b0;
		next_st = st;
		next_st.char_d  = rclk_s;
		next_st.train_d = tclk_s;
		next_st.data_d  = sel_data;

		// register port: writes
		if (reg_wr_i)
		begin
			if (reg_addr_i == REG_GLOBAL)
				next_st.thresh = reg_wdata_i[1:0];
			else
				for (int c = 0; c < NCH; c++)
					if (ch_hit(reg_addr_i, c))
						next_st.cfg[c] = reg_wdata_i;
		end

		// register port: reads, unmapped reads return zero
		next_st.rdata = '0;
		if (reg_rd_i)
		begin
			if (reg_addr_i == REG_GLOBAL)
				next_st.rdata = {6'h00, st.thresh};
			else if (reg_addr_i == REG_STATUS)
				next_st.rdata = {4'h0, st.fault_n};
			else if (reg_addr_i == REG_RANGE)
				next_st.rdata = {forcing, locked};
			else
				for (int c = 0; c < NCH; c++)
					if (ch_hit(reg_addr_i, c))
						next_st.rdata = st.cfg[c];
		end

		for (int c = 0; c < NCH; c++)
		begin
			next_st.band[c] = band_decode(st.cfg[c][CF_BAND+:2]);

			// transition density, counted in characters of ten bits
			if (sel_data[c] != st.data_d[c])
				next_st.idle_chars[c] = '0;
			else if (char_tick[c] && (st.idle_chars[c] != '1))
				next_st.idle_chars[c] = st.idle_chars[c] + IDLE_W'(1);

			// training clock presence
			if (train_tick[c])
				next_st.train_idle[c] = '0;
			else if (st.train_idle[c] != '1)
				next_st.train_idle[c] = st.train_idle[c] + TRAIN_W'(1);

			// enable settle: ignore status while the loop powers up
			if (!st.cfg[c][CF_EN])
				next_st.en_settle[c] = SETTLE_W'(ENABLE_SETTLE_CYC);
			else if (st.en_settle[c] != '0)
				next_st.en_settle[c] = st.en_settle[c] - SETTLE_W'(1);

			lvl = sel_s[c] ? pamp_s[2*c+:2] : samp_s[2*c+:2];
			valid = amp_ok(st.thresh, lvl)
				&& (st.idle_chars[c] <= NO_TRANS_CHARS)
				&& locked[c] && !forcing[c]
				&& (st.train_idle[c] < TRAIN_LOSS)
				&& !ffr_s[c]
				&& !((st.band[c] == BAND_LOW) && st.cfg[c][CF_RATE])
				&& (st.en_settle[c] == '0);

			if (!st.cfg[c][CF_EN])
				next_st.fault_n[c] = 1'b0;
			else if (char_tick[c])
				next_st.fault_n[c] = valid;

			// reclocker: logic runs while either driver is on
			next_st.rk_on[c] = st.cfg[c][CF_OE1] || st.cfg[c][CF_OE2];
			if (!next_st.rk_on[c])
				next_st.rk_settle[c] = RK_W'(RECLK_SETTLE_CYC);
			else if (st.rk_settle[c] != '0)
				next_st.rk_settle[c] = st.rk_settle[c] - RK_W'(1);
			// outputs stay quiet until the output loop has settled
			next_st.rk1[c] = st.rk_on[c] && (st.rk_settle[c] == '0)
				&& st.cfg[c][CF_OE1] && st.data_d[c];
			next_st.rk2[c] = st.rk_on[c] && (st.rk_settle[c] == '0)
				&& st.cfg[c][CF_OE2] && st.data_d[c];
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			st        <= '0;
			st.thresh <= THRESH_RST;
			st.cfg    <= {NCH{CFG_RST}};
		end
		else
			st <= next_st;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata_o        = st.rdata;
	assign link_fault_out_n_o = st.fault_n;
	assign force_training_o   = forcing;
	assign speed_band_o       = st.band;
	assign reclock_logic_en_o = st.rk_on;
	assign reclock_out1_o     = st.rk1;
	assign reclock_out2_o     = st.rk2;

	for (genvar g = 0; g < NCH; g++)
	begin : g_out
		assign loop_enable_o[g]     = st.cfg[g][CF_EN];
		assign reclock_out1_en_o[g] = st.cfg[g][CF_OE1];
		assign reclock_out2_en_o[g] = st.cfg[g][CF_OE2];
	end

	AST_RESET_DRIVERS: assert property (@(posedge sys_clk_i)
		!nrst_i |=> reclock_out1_en_o == '0 && reclock_out2_en_o == '0)
		else $error("drivers enabled after reset");
	AST_READ_GLOBAL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		reg_rd_i && reg_addr_i == REG_GLOBAL |=> reg_rdata_o == {6'h00, $past(st.thresh)})
		else $error("threshold read back wrong");
	AST_AMP_LOW: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		st.thresh != AMP_OFF && sel_s[0] && pamp_s[1:0] < st.thresh && char_tick[0]
		|=> !link_fault_out_n_o[0])
		else $error("low amplitude not faulted");
endmodule : lfr_top

// ---- tb/lfr_partner.sv ----
`timescale 1ns/1ps
module lfr_partner
	import lfr_pkg::*;
(
	input  wire logic           sys_clk_i,
	input  wire logic [NCH-1:0] prim_run_i,
	input  wire logic [NCH-1:0] sec_run_i,
	input  wire logic [NCH-1:0] half_rate_i,
	input  wire logic           redundant_i,
	input  wire logic [NCH-1:0] link_fault_out_n_i,
	output logic      [NCH-1:0] recovered_clock_o,
	output logic      [NCH-1:0] training_clock_o,
	output logic      [NCH-1:0] primary_serial_o,
	output logic      [NCH-1:0] secondary_serial_o,
	output logic      [NCH-1:0] line_input_select_o
);
	// ********
	// remote transmitters and host switch logic
	// ********
	logic [4:0]     phase;
	logic [NCH-1:0] fault_n_q;
	initial
	begin
		phase               = 5'h00;
		fault_n_q           = 4'h0;
		recovered_clock_o   = 4'h0;
		training_clock_o    = 4'h0;
		primary_serial_o    = 4'h0;
		secondary_serial_o  = 4'h5;
		line_input_select_o = 4'hF;
	end
	always @(posedge sys_clk_i)
	begin
		phase             <= phase + 5'h01;
		recovered_clock_o <= {NCH{phase[3]}};
		// half rate runs at half the character clock
		for (int c = 0; c < NCH; c++)
			training_clock_o[c] <= half_rate_i[c] ? phase[4] : phase[3];
		// a stopped stream holds its level: no transitions at all
		if (phase[3:0] == 4'hF)
		begin
			primary_serial_o   <= primary_serial_o ^ prim_run_i;
			secondary_serial_o <= secondary_serial_o ^ sec_run_i;
		end
		fault_n_q <= link_fault_out_n_i;
		if (redundant_i)
			line_input_select_o <= line_input_select_o ^ (fault_n_q & ~link_fault_out_n_i);
	end
endmodule : lfr_partner

// ---- tb/lfr_top_tb.sv ----
`timescale 1ns/1ps
module lfr_top_tb
	import lfr_pkg::*;
;
	// ********
	// bench setup
	// ********
	localparam int WIN = 16 * 16;
	typedef struct packed {
		logic [1:0] thr;
		logic [1:0] pa;
		logic [1:0] sa;
		logic       e;
	} lfr_row_t;
	lfr_row_t rows [7] = '{'{2'h0, 2'h0, 2'h0, 1'b1}, '{2'h1, 2'h0, 2'h3, 1'b0},
		'{2'h1, 2'h1, 2'h0, 1'b1}, '{2'h2, 2'h1, 2'h3, 1'b0}, '{2'h2, 2'h2, 2'h0, 1'b1},
		'{2'h3, 2'h2, 2'h3, 1'b0}, '{2'h3, 2'h3, 2'h0, 1'b1}};
	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	logic [AW-1:0]    addr = 3'h0;
	logic [DW-1:0]    wdata = 8'h00;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic [DW-1:0]    rdata;
	logic [NCH-1:0]   sel, prim, sec, rclk, tclk, fault_n, loop_en, force_t;
	logic [NCH-1:0]   rk_en, o1en, o2en, o1, o2;
	logic [NCH-1:0]   ffr = 4'h0;
	logic [NCH-1:0]   prun = 4'hF;
	logic [NCH-1:0]   srun = 4'hF;
	logic [NCH-1:0]   half = 4'h0;
	logic             redund = 1'b0;
	logic [2*NCH-1:0] pamp = 8'hFF;
	logic [2*NCH-1:0] samp = 8'h00;
	logic [2*NCH-1:0] band;
	int               fail_count = 0;
	int               checks_done = 0;
	int               n;
	logic             s;
	initial
	begin
		forever #4 clk = ~clk;
	end
	lfr_top #(.RANGE_PERIOD_CHARS(16), .ENABLE_SETTLE_CYC(20), .RECLK_SETTLE_CYC(10)) lfr_top_i (
		.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .line_input_select_i(sel),
		.primary_serial_in_i(prim), .secondary_serial_in_i(sec),
		.primary_amp_level_i(pamp), .secondary_amp_level_i(samp),
		.recovered_clock_i(rclk), .training_clock_i(tclk), .forced_fault_request_i(ffr),
		.link_fault_out_n_o(fault_n), .loop_enable_o(loop_en), .force_training_o(force_t),
		.speed_band_o(band), .reclock_logic_en_o(rk_en), .reclock_out1_en_o(o1en),
		.reclock_out2_en_o(o2en), .reclock_out1_o(o1), .reclock_out2_o(o2));
	lfr_partner lfr_partner_i (
		.sys_clk_i(clk), .prim_run_i(prun), .sec_run_i(srun), .half_rate_i(half),
		.redundant_i(redund), .link_fault_out_n_i(fault_n), .recovered_clock_o(rclk),
		.training_clock_o(tclk), .primary_serial_o(prim), .secondary_serial_o(sec),
		.line_input_select_o(sel));
	// ********
	// tasks
	// ********
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic reg_write(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : reg_write
	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 chk("register", e, rdata);
	endtask : rd_chk
	// bounded wait for a fault level; n returns the cycles spent
	task automatic wait_fn(input int c, input logic e);
		n = 0;
		while (fault_n[c] !== e && n < 3000)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 3000)
		begin
			fail_count++;
			$display("[FAIL] fault_n wait expected %0h seen %0h", e, fault_n[c]);
			test_done();
		end
	endtask : wait_fn
	initial
	begin
		repeat (100000) @(posedge clk);
		fail_count++;
		$display("[FAIL] run limit expected end seen hang");
		test_done();
	end
	// ********
	// main sequence
	// ********
	initial
	begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		tick(1);
		chk("fault_n", 8'h00, 8'(fault_n));
		chk("out_en", 8'h00, {o2en, o1en});
		rd_chk(REG_GLOBAL, {6'h00, THRESH_RST});
		rd_chk(REG_CH_BASE, CFG_RST);
		rd_chk(3'h7, 8'h00);
		for (int c = 0; c < NCH; c++)
			reg_write(REG_CH_BASE + 3'(c), 8'h03);
		tick(1);
		chk("loop_en", 8'h0F, 8'(loop_en));
		wait_fn(0, 1'b1);
		chk("lock time", 8'h01, 8'(n >= WIN - 3 * 2 * 16));
		foreach (rows[r])
		begin
			reg_write(REG_GLOBAL, {6'h00, rows[r].thr});
			pamp <= {NCH{rows[r].pa}};
			samp <= {NCH{rows[r].sa}};
			tick(48);
			for (int c = 0; c < NCH; c++)
			begin
				wait_fn(c, rows[r].e);
				chk("fault_n", 8'(rows[r].e), 8'(fault_n[c]));
			end
		end
		rd_chk(REG_STATUS, 8'h0F);
		rd_chk(REG_RANGE, 8'h0F);
		reg_write(3'h7, 8'hFF);
		rd_chk(REG_GLOBAL, 8'h03);
		// forced fault on one channel only
		ffr[1] <= 1'b1;
		wait_fn(1, 1'b0);
		chk("fault_n", 8'h0D, 8'(fault_n));
		ffr[1] <= 1'b0;
		wait_fn(1, 1'b1);
		// training clock at the wrong rate drives the loop out of range
		half[1] <= 1'b1;
		for (n = 0; n < 3000 && force_t[1] !== 1'b1; n++)
			tick(1);
		chk("force_training", 8'h01, 8'(force_t[1]));
		// fault follows at the next character tick, one character later
		tick(18);
		chk("forced fault_n", 8'h00, 8'(fault_n[1]));
		half[1] <= 1'b0;
		wait_fn(1, 1'b1);
		// stalled stream on one channel
		prun[2] <= 1'b0;
		wait_fn(2, 1'b0);
		chk("idle span", 8'h01, 8'(n > 80 && n < 144));
		chk("fault_n", 8'h0B, 8'(fault_n));
		prun[2] <= 1'b1;
		wait_fn(2, 1'b1);
		// redundant link: host swaps to the secondary stream
		pamp   <= 8'hFF;
		samp   <= 8'hFF;
		redund <= 1'b1;
		prun[0] <= 1'b0;
		wait_fn(0, 1'b0);
		wait_fn(0, 1'b1);
		redund <= 1'b0;
		chk("line select", 8'h0E, 8'(sel));
		// disable and re-enable a channel
		reg_write(REG_CH_BASE + 3'h3, 8'h00);
		tick(1);
		chk("fault_n", 8'h07, 8'(fault_n));
		chk("loop_en", 8'h07, 8'(loop_en));
		reg_write(REG_CH_BASE + 3'h3, 8'h03);
		tick(10);
		chk("fault_n", 8'h00, 8'(fault_n[3]));
		wait_fn(3, 1'b1);
		// speed bands, reserved low band half rate, valid half rate
		for (int b = 0; b < 4; b++)
		begin
			reg_write(REG_CH_BASE + 3'h2, {5'h00, 2'(b), 1'b1});
			tick(1);
			chk("band", (b == 3) ? 8'h01 : 8'(b), 8'(band[5:4]));
		end
		reg_write(REG_CH_BASE + 3'h2, 8'h09);
		wait_fn(2, 1'b0);
		half[2] <= 1'b1;
		reg_write(REG_CH_BASE + 3'h2, 8'h0B);
		wait_fn(2, 1'b1);
		chk("fault_n", 8'h01, 8'(fault_n[2]));
		// reclocker drivers
		reg_write(REG_CH_BASE, 8'h13);
		tick(1);
		chk("drivers", 8'h11, {3'h0, rk_en[0], 2'h0, o2en[0], o1en[0]});
		tick(3);
		chk("out1 settling", 8'h00, 8'(o1[0]));
		tick(20);
		s = sec[0];
		for (n = 0; n < 40 && sec[0] === s; n++)
			tick(1);
		tick(8);
		chk("out1", 8'(sec[0]), 8'(o1[0]));
		reg_write(REG_CH_BASE, 8'h33);
		tick(14);
		chk("out2", {7'h00, sec[0]}, {7'h00, o2[0]});
		reg_write(REG_CH_BASE, 8'h03);
		tick(2);
		chk("rk off", 8'h00, {5'h00, rk_en[0], o2[0], o1[0]});
		reg_write(REG_CH_BASE, 8'h33);
		tick(2);
		// mid-run reset
		nrst <= 1'b0;
		tick(4);
		chk("out_en", 8'h00, {o2en, o1en});
		nrst <= 1'b1;
		rd_chk(REG_CH_BASE, CFG_RST);
		test_done();
	end
endmodule : lfr_top_tb
